// [rbe_error_report.sv]
// What this block does
// [RULE1] Bad split completion sets two status flags
// [RULE2] Log its header when unmasked, pointer free
// [RULE3] Error signal needs unmasked plus enable path
// [RULE4] Interrupt or MSI needs matching reporting enables
// [RULE5] Set fatal or nonfatal detected by severity
// [RULE6] Signaled error needs unmasked and command enable
// [RULE7] Split message data error sets, logs
// [RULE8] Link-up timeout acts as unsupported completion
// [RULE9] Timeout logs request header, first pointer
// [RULE10] Timeout: error secondary bits, interrupt primary
// [RULE11] Per-transaction discard timers set two flags
// [RULE12] Discard expiry qualified by primary bits
// [RULE13] Nonfatal or fatal message sets received flag
// [RULE14] Message error signal by root or SERR enables
// [RULE15] Message interrupt by root error command enable
// [RULE16] Severity bit set means fatal
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ns
module rbe_error_report
    import rbe_pkg::*;
#(
    parameter logic [RBE_DT_CW-1:0] DT_LIMIT = RBE_DT_LIMIT_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire logic i_split_unexp,
    input wire logic i_split_data_err,
    input wire logic [127:0] i_split_hdr,
    input wire logic i_link_up,
    input wire logic i_cpl_timeout,
    input wire logic [127:0] i_req_hdr,
    input wire logic [RBE_DT_N-1:0] i_dt_queue,
    input wire logic [RBE_DT_N-1:0] i_dt_done,
    input wire logic i_msg_valid,
    input wire rbe_msg_type i_msg_class,
    output logic o_system_error_out_n,
    output logic o_legacy_interrupt_a_out_n,
    output logic o_msi_req,
    output logic o_ur_cpl,
    output logic o_irq
);

    // ****************************************
    // Qualification helpers
    // ****************************************
    function automatic logic serr_ok(input rbe_ctl_type c, input logic msk, input logic sev);
        // [RULE16] Severity set selects fatal
        serr_ok = !msk && (c.cmd_serr_en ||
            (sev ? (c.dev_fatal_rep && c.rc_se_fatal) : (c.dev_nonfatal_rep && c.rc_se_nonfatal)));
    endfunction

    function automatic logic int_ok(input rbe_ctl_type c, input logic msk, input logic sev);
        int_ok = !c.cmd_int_dis && !msk && (sev ? c.rec_fatal_en : c.rec_nonfatal_en) &&
            (c.cmd_serr_en || (sev ? c.dev_fatal_rep : c.dev_nonfatal_rep));
    endfunction

    function automatic logic [31:0] w1c(input logic [31:0] q, input logic [31:0] clr,
        input logic [31:0] set);
        // Hardware set wins over a software clear in the same cycle
        w1c = (q & ~clr) | set;
    endfunction

    rbe_ctl_type ctl_q;
    logic [31:0] sec_mask_q, sec_sev_q, sec_stat_q, pri_mask_q, pri_sev_q, pri_stat_q;
    logic [31:0] stat_q;
    logic [31:0] sec_hdr_q [4];
    logic [31:0] pri_hdr_q [4];
    logic [4:0] sec_ptr_q, pri_ptr_q;
    rbe_evt_type evt_stat_q, evt_mask_q, ev;
    logic [RBE_DT_CW-1:0] dt_cnt_q [RBE_DT_N];
    logic [RBE_DT_N-1:0] dt_busy_q, dt_hit;
    logic ack_q;
    logic [31:0] rdat_q;
    logic serr_q, msi_q, ur_q;

    // ****************************************
    // Bus decode
    // ****************************************
    logic bus_req, wr_acc, rd_acc;
    logic [31:0] wmask;
    assign bus_req = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr_acc = bus_req && i_wb_we;
    assign rd_acc = bus_req && !i_wb_we;
    assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

    function automatic logic [31:0] clr_of(input logic hit, input logic [31:0] d,
        input logic [31:0] m);
        clr_of = hit ? (d & m) : RBE_ZERO32;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] q, input logic [31:0] d,
        input logic [31:0] m);
        merge = (q & ~m) | (d & m);
    endfunction

    // ****************************************
    // Events and their qualification
    // ****************************************
    logic sec_ptr_act, pri_ptr_act;
    logic m_unexp, m_scm, m_cto_s, m_cto_p, m_dt;
    logic s_unexp, s_scm, s_cto_s, s_cto_p, s_dt;
    logic msg_nf, msg_f, msg_cor, msg_serr, msg_int;
    logic serr_req, int_req, sig_set, fat_set, nf_set;

    assign sec_ptr_act = sec_stat_q[sec_ptr_q];
    assign pri_ptr_act = pri_stat_q[pri_ptr_q];
    assign m_unexp = sec_mask_q[RBE_SEC_UNEXP];
    assign s_unexp = sec_sev_q[RBE_SEC_UNEXP];
    assign m_scm = sec_mask_q[RBE_SEC_SCM_DATA];
    assign s_scm = sec_sev_q[RBE_SEC_SCM_DATA];
    assign m_cto_s = sec_mask_q[RBE_SEC_CTO];
    assign s_cto_s = sec_sev_q[RBE_SEC_CTO];
    assign m_cto_p = pri_mask_q[RBE_PRI_CTO];
    assign s_cto_p = pri_sev_q[RBE_PRI_CTO];
    assign m_dt = pri_mask_q[RBE_PRI_DT];
    assign s_dt = pri_sev_q[RBE_PRI_DT];

    assign ev.unexp = i_split_unexp;
    assign ev.scm = i_split_data_err;
    // [RULE8] Timeout counts only with the link up
    assign ev.cto = i_cpl_timeout && i_link_up;
    assign ev.dt = |dt_hit;
    assign ev.msg = i_msg_valid;
    assign msg_cor = i_msg_valid && (i_msg_class == RBE_MSG_COR);
    assign msg_nf = i_msg_valid && (i_msg_class == RBE_MSG_NONFATAL);
    assign msg_f = i_msg_valid && (i_msg_class == RBE_MSG_FATAL);

    // [RULE14] Message error signal paths
    assign msg_serr = (msg_cor && ctl_q.rc_se_cor) || (msg_nf && ctl_q.rc_se_nonfatal) ||
        (msg_f && ctl_q.rc_se_fatal) ||
        ((msg_nf || msg_f) && ctl_q.cmd_serr_en && ctl_q.bctl_serr_en);
    // [RULE15] Message interrupt paths
    assign msg_int = (msg_cor && ctl_q.rec_cor_en) || (msg_nf && ctl_q.rec_nonfatal_en) ||
        (msg_f && ctl_q.rec_fatal_en);

    // [RULE3] Error signal gating, per class
    // [RULE10] Timeout error signal uses secondary bits
    // [RULE12] Discard expiry uses primary bits
    assign serr_req = (ev.unexp && serr_ok(ctl_q, m_unexp, s_unexp)) ||
        (ev.scm && serr_ok(ctl_q, m_scm, s_scm)) ||
        (ev.cto && serr_ok(ctl_q, m_cto_s, s_cto_s)) ||
        (ev.dt && serr_ok(ctl_q, m_dt, s_dt)) || msg_serr;
    // [RULE4] Interrupt gating, per class
    // [RULE10] Timeout interrupt uses primary bits
    assign int_req = (ev.unexp && int_ok(ctl_q, m_unexp, s_unexp)) ||
        (ev.scm && int_ok(ctl_q, m_scm, s_scm)) ||
        (ev.cto && int_ok(ctl_q, m_cto_p, s_cto_p)) ||
        (ev.dt && int_ok(ctl_q, m_dt, s_dt)) || msg_int;
    // [RULE6] Signaled error needs unmasked and command enable
    assign sig_set = ctl_q.cmd_serr_en && ((ev.unexp && !m_unexp) || (ev.scm && !m_scm) ||
        (ev.cto && !m_cto_s) || (ev.dt && !m_dt));
    // [RULE5] Detected bit follows severity
    assign fat_set = (ev.unexp && s_unexp) || (ev.scm && s_scm) || (ev.cto && s_cto_p) ||
        (ev.dt && s_dt);
    assign nf_set = (ev.unexp && !s_unexp) || (ev.scm && !s_scm) || (ev.cto && !s_cto_p) ||
        (ev.dt && !s_dt);

    // ****************************************
    // Discard timers
    // ****************************************
    always_comb begin
        for (int i = 0; i < RBE_DT_N; i++) begin
            dt_hit[i] = dt_busy_q[i] && (dt_cnt_q[i] == DT_LIMIT);
        end
    end

    // [RULE11] One timer per queued transaction
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dt_busy_q <= '0;
            for (int i = 0; i < RBE_DT_N; i++) begin
                dt_cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < RBE_DT_N; i++) begin
                if (i_dt_queue[i]) begin
                    dt_busy_q[i] <= 1'b1;
                    dt_cnt_q[i] <= '0;
                end else if (i_dt_done[i] || dt_hit[i]) begin
                    dt_busy_q[i] <= 1'b0;
                end else if (dt_busy_q[i]) begin
                    dt_cnt_q[i] <= dt_cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic w_ctl, w_smask, w_ssev, w_pmask, w_psev, w_emask;
    logic [31:0] ctl_new;
    assign ctl_new = merge(32'(ctl_q), i_wb_dat, wmask);
    assign w_ctl = wr_acc && (i_wb_adr == RBE_OFS_CTRL);
    assign w_smask = wr_acc && (i_wb_adr == RBE_OFS_SEC_MASK);
    assign w_ssev = wr_acc && (i_wb_adr == RBE_OFS_SEC_SEV);
    assign w_pmask = wr_acc && (i_wb_adr == RBE_OFS_PRI_MASK);
    assign w_psev = wr_acc && (i_wb_adr == RBE_OFS_PRI_SEV);
    assign w_emask = wr_acc && (i_wb_adr == RBE_OFS_EVT_MASK);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctl_q <= '0;
            sec_mask_q <= RBE_ZERO32;
            sec_sev_q <= RBE_ZERO32;
            pri_mask_q <= RBE_ZERO32;
            pri_sev_q <= RBE_ZERO32;
            evt_mask_q <= '0;
        end else begin
            if (w_ctl) begin
                ctl_q <= rbe_ctl_type'(ctl_new[RBE_CTL_W-1:0]);
            end
            if (w_smask) begin
                sec_mask_q <= merge(sec_mask_q, i_wb_dat, wmask);
            end
            if (w_ssev) begin
                sec_sev_q <= merge(sec_sev_q, i_wb_dat, wmask);
            end
            if (w_pmask) begin
                pri_mask_q <= merge(pri_mask_q, i_wb_dat, wmask);
            end
            if (w_psev) begin
                pri_sev_q <= merge(pri_sev_q, i_wb_dat, wmask);
            end
            if (w_emask) begin
                evt_mask_q <= rbe_evt_type'((i_wb_dat[RBE_EV_W-1:0] & wmask[RBE_EV_W-1:0])
                    | (evt_mask_q & ~wmask[RBE_EV_W-1:0]));
            end
        end
    end

    // ****************************************
    // Error status registers
    // ****************************************
    logic [31:0] sec_set, pri_set, st_set;
    always_comb begin
        sec_set = RBE_ZERO32;
        // [RULE1] Secondary unexpected split status
        sec_set[RBE_SEC_UNEXP] = ev.unexp;
        // [RULE7] Split message data error status
        sec_set[RBE_SEC_SCM_DATA] = ev.scm;
        // [RULE11] Secondary discard expired status
        sec_set[RBE_SEC_DT] = ev.dt;
        pri_set = RBE_ZERO32;
        // [RULE8] Primary completion timeout status
        pri_set[RBE_PRI_CTO] = ev.cto;
        st_set = RBE_ZERO32;
        // [RULE1] Bridge unexpected split flag
        st_set[RBE_ST_PCIX_UNEXP] = ev.unexp;
        // [RULE11] Bridge control discard status
        st_set[RBE_ST_BCTL_DISCARD] = ev.dt;
        st_set[RBE_ST_DEV_FATAL] = fat_set;
        st_set[RBE_ST_DEV_NONFATAL] = nf_set;
        st_set[RBE_ST_SIG_SYS_ERR] = sig_set;
        // [RULE13] Received system error on message
        st_set[RBE_ST_RCV_SYS_ERR] = msg_nf || msg_f;
        st_set[RBE_ST_INTA_PEND] = int_req && !ctl_q.msi_en;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sec_stat_q <= RBE_ZERO32;
            pri_stat_q <= RBE_ZERO32;
            stat_q <= RBE_ZERO32;
        end else begin
            sec_stat_q <= w1c(sec_stat_q,
                clr_of(wr_acc && (i_wb_adr == RBE_OFS_SEC_STAT), i_wb_dat, wmask), sec_set);
            pri_stat_q <= w1c(pri_stat_q,
                clr_of(wr_acc && (i_wb_adr == RBE_OFS_PRI_STAT), i_wb_dat, wmask), pri_set);
            stat_q <= w1c(stat_q,
                clr_of(wr_acc && (i_wb_adr == RBE_OFS_STAT), i_wb_dat, wmask), st_set);
        end
    end

    // ****************************************
    // Header logs and first-error pointers
    // ****************************************
    logic sec_log_unexp, sec_log_scm, pri_log;
    // [RULE2] Log only when unmasked and pointer free
    assign sec_log_unexp = ev.unexp && !m_unexp && !sec_ptr_act;
    // [RULE7] Same conditions; unexpected wins a tie
    assign sec_log_scm = ev.scm && !m_scm && !sec_ptr_act && !sec_log_unexp;
    // [RULE9] Request header under primary mask
    assign pri_log = ev.cto && !m_cto_p && !pri_ptr_act;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sec_ptr_q <= '0;
            pri_ptr_q <= '0;
            for (int i = 0; i < 4; i++) begin
                sec_hdr_q[i] <= RBE_ZERO32;
                pri_hdr_q[i] <= RBE_ZERO32;
            end
        end else begin
            if (sec_log_unexp || sec_log_scm) begin
                sec_ptr_q <= sec_log_unexp ? RBE_SEC_UNEXP : RBE_SEC_SCM_DATA;
                for (int i = 0; i < 4; i++) begin
                    sec_hdr_q[i] <= i_split_hdr[32*i +: 32];
                end
            end
            if (pri_log) begin
                pri_ptr_q <= RBE_PRI_CTO;
                for (int i = 0; i < 4; i++) begin
                    pri_hdr_q[i] <= i_req_hdr[32*i +: 32];
                end
            end
        end
    end

    // ****************************************
    // Pin drivers and interrupt status
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            serr_q <= 1'b0;
            msi_q <= 1'b0;
            ur_q <= 1'b0;
            evt_stat_q <= '0;
        end else begin
            serr_q <= serr_req;
            // [RULE4] MSI when enabled, else legacy line
            msi_q <= int_req && ctl_q.msi_en;
            // [RULE8] Answer as an unsupported request
            ur_q <= ev.cto;
            if (rd_acc && (i_wb_adr == RBE_OFS_EVT_STAT)) begin
                evt_stat_q <= ev;
            end else begin
                evt_stat_q <= evt_stat_q | ev;
            end
        end
    end

    assign o_system_error_out_n = !serr_q;
    assign o_legacy_interrupt_a_out_n = !stat_q[RBE_ST_INTA_PEND];
    assign o_msi_req = msi_q;
    assign o_ur_cpl = ur_q;
    assign o_irq = |(evt_stat_q & evt_mask_q);

    // ****************************************
    // Bus answer
    // ****************************************
    logic [31:0] rmux;
    always_comb begin
        rmux = RBE_ZERO32;
        if ((i_wb_adr & RBE_HDR_BLK_MASK) == RBE_OFS_SEC_HDR) begin
            rmux = sec_hdr_q[i_wb_adr[3:2]];
        end else if ((i_wb_adr & RBE_HDR_BLK_MASK) == RBE_OFS_PRI_HDR) begin
            rmux = pri_hdr_q[i_wb_adr[3:2]];
        end else begin
            unique case (i_wb_adr)
                RBE_OFS_CTRL: rmux = 32'(ctl_q);
                RBE_OFS_SEC_MASK: rmux = sec_mask_q;
                RBE_OFS_SEC_SEV: rmux = sec_sev_q;
                RBE_OFS_SEC_STAT: rmux = sec_stat_q;
                RBE_OFS_PRI_MASK: rmux = pri_mask_q;
                RBE_OFS_PRI_SEV: rmux = pri_sev_q;
                RBE_OFS_STAT: rmux = stat_q;
                RBE_OFS_PRI_STAT: rmux = pri_stat_q;
                RBE_OFS_PRI_PTR: rmux = 32'(pri_ptr_q);
                RBE_OFS_EVT_STAT: rmux = 32'(evt_stat_q);
                RBE_OFS_EVT_MASK: rmux = 32'(evt_mask_q);
                RBE_OFS_SEC_PTR: rmux = 32'(sec_ptr_q);
                default: rmux = RBE_ZERO32;
            endcase
        end
    end

    // Unmapped addresses still ack so a stray access never hangs the bus
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
            rdat_q <= RBE_ZERO32;
        end else begin
            ack_q <= bus_req;
            rdat_q <= rd_acc ? rmux : RBE_ZERO32;
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_cto_seen;
        i_cpl_timeout && i_link_up;
    endsequence

    sequence s_ur_pulse;
        o_ur_cpl ##1 !o_ur_cpl;
    endsequence

    a_unexp_flags: assert property ( // RULE1
        ev.unexp |=> sec_stat_q[RBE_SEC_UNEXP] && stat_q[RBE_ST_PCIX_UNEXP])
        else $error("unexpected split flags not set");
    a_sec_log_ptr: assert property ( // RULE2
        ev.unexp && !m_unexp && !sec_ptr_act |=> sec_ptr_q == RBE_SEC_UNEXP &&
        sec_hdr_q[0] == $past(i_split_hdr[31:0]))
        else $error("secondary header not logged");
    a_serr_cause: assert property ( // RULE3
        !o_system_error_out_n |-> $past(serr_req))
        else $error("system error without cause");
    a_msi_cause: assert property ( // RULE4
        o_msi_req |-> $past(int_req) && $past(ctl_q.msi_en) && o_legacy_interrupt_a_out_n ||
        $past(stat_q[RBE_ST_INTA_PEND]))
        else $error("msi without qualified cause");
    a_dev_fatal: assert property ( // RULE5
        ev.unexp && s_unexp |=> stat_q[RBE_ST_DEV_FATAL])
        else $error("fatal detected not set");
    a_sig_serr: assert property ( // RULE6
        ev.scm && !m_scm && ctl_q.cmd_serr_en |=> stat_q[RBE_ST_SIG_SYS_ERR])
        else $error("signaled system error not set");
    a_scm_status: assert property ( // RULE7
        ev.scm |=> sec_stat_q[RBE_SEC_SCM_DATA])
        else $error("split data error status not set");
    a_cto_ur: assert property ( // RULE8
        s_cto_seen ##1 !(i_cpl_timeout && i_link_up) |-> s_ur_pulse and
        ##1 pri_stat_q[RBE_PRI_CTO])
        else $error("timeout not answered as unsupported");
    a_cto_log: assert property ( // RULE9
        s_cto_seen ##0 !m_cto_p && !pri_ptr_act |=> pri_ptr_q == RBE_PRI_CTO &&
        pri_hdr_q[3] == $past(i_req_hdr[127:96]))
        else $error("request header not logged");
    a_dt_flags: assert property ( // RULE11
        |dt_hit |=> stat_q[RBE_ST_BCTL_DISCARD] && sec_stat_q[RBE_SEC_DT])
        else $error("discard expiry flags not set");
    a_msg_rcv: assert property ( // RULE13
        msg_f |=> stat_q[RBE_ST_RCV_SYS_ERR])
        else $error("received system error not set");
    a_msg_serr: assert property ( // RULE14
        msg_cor && ctl_q.rc_se_cor |=> !o_system_error_out_n)
        else $error("message did not raise system error");
    a_msg_int: assert property ( // RULE15
        msg_nf && ctl_q.rec_nonfatal_en && ctl_q.msi_en |=> o_msi_req)
        else $error("message did not raise msi");

endmodule

// [rbe_pkg.sv]
package rbe_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [11:0] RBE_OFS_CTRL = 12'h000;
    localparam logic [11:0] RBE_OFS_SEC_MASK = 12'h004;
    localparam logic [11:0] RBE_OFS_SEC_SEV = 12'h008;
    localparam logic [11:0] RBE_OFS_SEC_STAT = 12'h00C;
    localparam logic [11:0] RBE_OFS_PRI_MASK = 12'h010;
    localparam logic [11:0] RBE_OFS_PRI_SEV = 12'h014;
    localparam logic [11:0] RBE_OFS_STAT = 12'h018;
    localparam logic [11:0] RBE_OFS_PRI_STAT = 12'h01C;
    localparam logic [11:0] RBE_OFS_SEC_HDR = 12'h020;
    localparam logic [11:0] RBE_OFS_PRI_HDR = 12'h030;
    localparam logic [11:0] RBE_OFS_PRI_PTR = 12'h040;
    localparam logic [11:0] RBE_OFS_EVT_STAT = 12'h044;
    localparam logic [11:0] RBE_OFS_EVT_MASK = 12'h048;
    localparam logic [11:0] RBE_OFS_SEC_PTR = 12'hFEC;
    localparam logic [11:0] RBE_HDR_BLK_MASK = 12'hFF0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam logic [4:0] RBE_SEC_UNEXP = 5'h00;
    localparam logic [4:0] RBE_SEC_SCM_DATA = 5'h01;
    localparam logic [4:0] RBE_SEC_DT = 5'h02;
    localparam logic [4:0] RBE_SEC_CTO = 5'h03;
    localparam logic [4:0] RBE_PRI_DT = 5'h03;
    localparam logic [4:0] RBE_PRI_CTO = 5'h0E;
    localparam int RBE_ST_PCIX_UNEXP = 0;
    localparam int RBE_ST_BCTL_DISCARD = 1;
    localparam int RBE_ST_DEV_FATAL = 2;
    localparam int RBE_ST_DEV_NONFATAL = 3;
    localparam int RBE_ST_SIG_SYS_ERR = 4;
    localparam int RBE_ST_RCV_SYS_ERR = 5;
    localparam int RBE_ST_INTA_PEND = 6;
    localparam int RBE_EV_W = 5;
    localparam int RBE_CTL_W = 12;
    localparam int RBE_DT_N = 4;
    localparam int RBE_DT_CW = 20;

    localparam logic [31:0] RBE_ZERO32 = 32'h0000_0000;
    localparam logic [RBE_DT_CW-1:0] RBE_DT_LIMIT_DEF = 20'h08000;

    // Control fields, bit 0 is the command SERR enable
    typedef struct packed {
        logic msi_en;
        logic rec_fatal_en;
        logic rec_nonfatal_en;
        logic rec_cor_en;
        logic rc_se_fatal;
        logic rc_se_nonfatal;
        logic rc_se_cor;
        logic dev_fatal_rep;
        logic dev_nonfatal_rep;
        logic bctl_serr_en;
        logic cmd_int_dis;
        logic cmd_serr_en;
    } rbe_ctl_type;

    // Event pulses, also the layout of the interrupt status and mask
    typedef struct packed {
        logic msg;
        logic dt;
        logic cto;
        logic scm;
        logic unexp;
    } rbe_evt_type;

    typedef enum logic [1:0] {
        RBE_MSG_COR,
        RBE_MSG_NONFATAL,
        RBE_MSG_FATAL
    } rbe_msg_type;

endpackage

// [rbe_far_model.sv]
`timescale 1ns/1ns
module rbe_far_model
    import rbe_pkg::*;
(
    input wire logic i_clk,
    output logic [4:0] o_ev,
    output logic [127:0] o_hdr,
    output rbe_msg_type o_cls
);
    // Bits: unexpected, data error, timeout, message, queue entry 0
    initial begin
        o_ev = 5'h00;
        o_hdr = 128'h0;
        o_cls = RBE_MSG_COR;
    end
    task automatic ev(input int k, input logic [127:0] h, input rbe_msg_type c);
        @(posedge i_clk);
        o_ev <= 5'h01 << k;
        o_hdr <= h;
        o_cls <= c;
        @(posedge i_clk);
        o_ev <= 5'h00;
        // Released header must not look valid
        o_hdr <= ~h;
    endtask
endmodule

// [reverse_bridge_error_reporting_tb.sv]
`timescale 1ns/1ns
module reverse_bridge_error_reporting_tb;
    import rbe_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0, rdat, r;
    logic [4:0] ev;
    logic [127:0] hd, h;
    rbe_msg_type cls;
    logic ack, serr_n, inta_n, msi, ur, irq;
    logic [15:0] seed;
    int num_errors = 0, total_checks = 0;
    always #2 clk = ~clk;
    rbe_far_model fm (.i_clk(clk), .o_ev(ev), .o_hdr(hd), .o_cls(cls));
    rbe_error_report #(.DT_LIMIT(20'h00014)) uut (.i_core_clk(clk), .i_resetn(rstn),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wd), .o_wb_ack(ack), .o_wb_dat(rdat), .i_split_unexp(ev[0]),
        .i_split_data_err(ev[1]), .i_split_hdr(hd), .i_link_up(1'b1),
        .i_cpl_timeout(ev[2]), .i_req_hdr(hd), .i_dt_queue({3'h0, ev[4]}),
        .i_dt_done(4'h0), .i_msg_valid(ev[3]), .i_msg_class(cls),
        .o_system_error_out_n(serr_n), .o_legacy_interrupt_a_out_n(inta_n),
        .o_msi_req(msi), .o_ur_cpl(ur), .o_irq(irq));
    // ********
    // Checks and bus cycles
    // ********
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        if (n >= 50) begin
            num_errors++;
            finish_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    task automatic clr();
        wb(1'b1, RBE_OFS_STAT, 32'hFFFFFFFF);
        wb(1'b1, RBE_OFS_SEC_STAT, 32'hFFFFFFFF);
        wb(1'b1, RBE_OFS_PRI_STAT, 32'hFFFFFFFF);
    endtask
    // Expected {serr_n, inta_n, msi, ur} one cycle after the event
    task automatic pc(input int k, input rbe_msg_type c, input logic [3:0] e);
        fm.ev(k, h, c);
        #1 chk({28'h0, serr_n, inta_n, msi, ur}, {28'h0, e});
        @(posedge clk);
    endtask
    function automatic logic [127:0] rnd();
        logic [127:0] v;
        for (int i = 0; i < 8; i++) begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
            v = {v[111:0], seed};
        end
        return v;
    endfunction
    initial begin
        seed = 16'h004C;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(RBE_OFS_STAT, 32'h0);
        rd(12'h800, 32'h0);
        wb(1'b1, RBE_OFS_CTRL, 32'h001);
        wb(1'b1, RBE_OFS_EVT_MASK, 32'h1F);
        h = rnd();
        pc(0, RBE_MSG_COR, 4'h4);
        chk({31'h0, irq}, 32'h1);
        rd(RBE_OFS_STAT, 32'h19);
        rd(RBE_OFS_SEC_STAT, 32'h1);
        rd(RBE_OFS_SEC_HDR, h[31:0]);
        rd(RBE_OFS_EVT_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        clr();
        wb(1'b1, RBE_OFS_SEC_MASK, 32'h2);
        r = h[31:0];
        h = rnd();
        pc(1, RBE_MSG_COR, 4'hC);
        rd(RBE_OFS_SEC_HDR, r);
        rd(RBE_OFS_STAT, 32'h08);
        clr();
        wb(1'b1, RBE_OFS_SEC_MASK, 32'h0);
        wb(1'b1, RBE_OFS_SEC_SEV, 32'h1);
        wb(1'b1, RBE_OFS_CTRL, 32'h401);
        pc(0, RBE_MSG_COR, 4'h0);
        rd(RBE_OFS_STAT, 32'h55);
        clr();
        wb(1'b1, RBE_OFS_CTRL, 32'hC01);
        pc(0, RBE_MSG_COR, 4'h6);
        clr();
        wb(1'b1, RBE_OFS_SEC_MASK, 32'h8);
        wb(1'b1, RBE_OFS_CTRL, 32'h001);
        h = rnd();
        pc(2, RBE_MSG_COR, 4'hD);
        rd(RBE_OFS_PRI_STAT, 32'h4000);
        rd(RBE_OFS_PRI_HDR, h[31:0]);
        clr();
        wb(1'b1, RBE_OFS_CTRL, 32'h0E0);
        for (int k = 0; k < 3; k++) begin
            pc(3, rbe_msg_type'(k), 4'h4);
            rd(RBE_OFS_STAT, (k > 0) ? 32'h20 : 32'h0);
            clr();
        end
        wb(1'b1, RBE_OFS_CTRL, 32'hA00);
        pc(3, RBE_MSG_NONFATAL, 4'hE);
        clr();
        fm.ev(4, h, RBE_MSG_COR);
        // Expiry lands a fixed count after queueing
        repeat (30) @(posedge clk);
        wb(1'b0, RBE_OFS_STAT, 32'h0);
        chk(r & 32'h2, 32'h2);
        wb(1'b0, RBE_OFS_SEC_STAT, 32'h0);
        chk(r & 32'h4, 32'h4);
        finish_test();
    end
endmodule
